// File: ocr_pkg.sv
// Constants and types for the output channel configuration registers
package ocr_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OCR_CH01_OUTPUT_DIVIDER_OFS = 8'h21;
  localparam logic [7:0] OCR_CH2_OUTPUT_CONTROL_OFS = 8'h22;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] OCR_CH01_DIV_RST = 8'h01;
  localparam logic OCR_RESERVED_BIT_RST = 1'h1;
  localparam logic [1:0] OCR_CH2_FORMAT_RST = 2'h1;
  localparam logic [1:0] OCR_CH2_CUR_POS_RST = 2'h2;
  localparam logic [1:0] OCR_CH2_LOAD_NEG_RST = 2'h0;
  localparam logic [7:0] OCR_UNMAPPED_READ = 8'h00;

  // ****************************************
  // Field positions of the channel 2 control register
  // ****************************************
  localparam int OCR_RESERVED_BIT_POS = 7;
  localparam int OCR_FORMAT_LSB = 5;
  localparam int OCR_CUR_POS_LSB = 3;
  localparam int OCR_LOAD_NEG_LSB = 1;
  localparam int OCR_LOW_RESERVED_POS = 0;

  // ****************************************
  // Decoded physical values
  // ****************************************
  localparam logic [4:0] OCR_TAIL_4MA = 5'h04;
  localparam logic [4:0] OCR_TAIL_6MA = 5'h06;
  localparam logic [4:0] OCR_TAIL_8MA = 5'h08;
  localparam logic [4:0] OCR_TAIL_16MA = 5'h10;
  localparam logic [7:0] OCR_LOAD_50OHM = 8'h32;
  localparam logic [7:0] OCR_LOAD_100OHM = 8'h64;
  localparam logic [7:0] OCR_LOAD_200OHM = 8'hC8;

  typedef enum logic [1:0] {
    OCR_FMT_DISABLED = 2'b00,
    OCR_FMT_AC_DIFF = 2'b01,
    OCR_FMT_HCSL = 2'b10,
    OCR_FMT_LVCMOS = 2'b11
  } ocr_format_e;

  typedef enum logic [1:0] {
    OCR_PIN_OFF_TRISTATE = 2'b00,
    OCR_PIN_OFF_LOW = 2'b01,
    OCR_PIN_ON_INVERTED = 2'b10,
    OCR_PIN_ON_TRUE = 2'b11
  } ocr_pin_mode_e;

endpackage

// File: ocr_div_if.sv
// Carrier between the register bank and the shared channel 0/1 divider
interface ocr_div_if;
  logic [7:0] div_code;
  logic tick;

  modport regs (output div_code, input tick);
  modport divider (input div_code, output tick);
endinterface

// File: ocr_divider.sv
// Shared channel 0/1 divider: one tick every div_code plus one cycles
module ocr_divider (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Divider carrier
  ocr_div_if.divider div
);

  logic [7:0] count_q;

  // ****************************************
  // Ratio counter
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= 8'h00;
    end else if (count_q >= div.div_code) begin
      count_q <= 8'h00;
    end else begin
      count_q <= count_q + 8'h01;
    end
  end

  // Code 0x00 ticks every cycle, 0xFF every 256th cycle
  assign div.tick = (count_q >= div.div_code);

endmodule

// File: ocr_output_channel_config_regs.sv
// Output channel 0/1 divider and channel 2 driver control registers
// Operation
// - Channels 0 and 1 divide by divider code plus one, ratio 1 to 256.
// - One divider register serves channels 0 and 1, resets to 0x01, EEPROM kept.
// - Bits 6:5 pick channel 2 format: off, AC diff, HCSL, LVCMOS; reset 0x1.
// - Bits 4:3 pick tail current in differential formats; reset 0x2.
// - Bits 2:1 pick HCSL load: tristate, 50, 100, 200 ohm; reset zero.
// - In LVCMOS, bits 4:3 steer positive pin and bits 2:1 negative pin.
//
// Decided for this implementation: the plain strobed port.
module ocr_output_channel_config_regs (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // EEPROM image load and store
  input wire logic EE_LOAD_I,
  input wire logic [7:0] EE_DIV_I,
  input wire logic [7:0] EE_CTL_I,
  output logic [7:0] EE_DIV_O,
  output logic [7:0] EE_CTL_O,
  // Channel 0/1 divider
  output logic CH01_TICK_O,
  // Channel 2 driver controls
  output logic [1:0] CH2_FORMAT_O,
  output logic [4:0] CH2_TAIL_MA_O,
  output logic [7:0] CH2_LOAD_OHM_O,
  output logic CH2_POS_POWERED_O,
  output logic CH2_POS_OE_N_O,
  output logic CH2_POS_INVERT_O,
  output logic CH2_NEG_POWERED_O,
  output logic CH2_NEG_OE_N_O,
  output logic CH2_NEG_INVERT_O
);

  logic [7:0] ch01_output_divider_q;
  logic reserved_bit_q;
  logic [1:0] ch2_format_q;
  logic [1:0] ch2_current_or_pos_pin_q;
  logic [1:0] ch2_load_or_neg_pin_q;
  logic [7:0] ch2_output_control;
  logic wr_div;
  logic wr_ctl;
  logic [4:0] tail_ma_d;
  logic [7:0] load_ohm_d;
  logic [1:0] pin_code [2];
  logic pin_powered_q [2];
  logic pin_oe_n_q [2];
  logic pin_invert_q [2];

  ocr_div_if div_bus ();

  // ****************************************
  // Register writes and EEPROM load
  // ****************************************
  assign wr_div = WR_I && (ADDR_I == ocr_pkg::OCR_CH01_OUTPUT_DIVIDER_OFS);
  assign wr_ctl = WR_I && (ADDR_I == ocr_pkg::OCR_CH2_OUTPUT_CONTROL_OFS);

  // A bus write in the same cycle as an image load wins
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ch01_output_divider_q <= ocr_pkg::OCR_CH01_DIV_RST;
    end else if (wr_div) begin
      ch01_output_divider_q <= WDATA_I;
    end else if (EE_LOAD_I) begin
      ch01_output_divider_q <= EE_DIV_I;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      reserved_bit_q <= ocr_pkg::OCR_RESERVED_BIT_RST;
      ch2_format_q <= ocr_pkg::OCR_CH2_FORMAT_RST;
      ch2_current_or_pos_pin_q <= ocr_pkg::OCR_CH2_CUR_POS_RST;
      ch2_load_or_neg_pin_q <= ocr_pkg::OCR_CH2_LOAD_NEG_RST;
    end else if (wr_ctl) begin
      reserved_bit_q <= WDATA_I[ocr_pkg::OCR_RESERVED_BIT_POS];
      ch2_format_q <= WDATA_I[ocr_pkg::OCR_FORMAT_LSB +: 2];
      ch2_current_or_pos_pin_q <= WDATA_I[ocr_pkg::OCR_CUR_POS_LSB +: 2];
      ch2_load_or_neg_pin_q <= WDATA_I[ocr_pkg::OCR_LOAD_NEG_LSB +: 2];
    end else if (EE_LOAD_I) begin
      reserved_bit_q <= EE_CTL_I[ocr_pkg::OCR_RESERVED_BIT_POS];
      ch2_format_q <= EE_CTL_I[ocr_pkg::OCR_FORMAT_LSB +: 2];
      ch2_current_or_pos_pin_q <= EE_CTL_I[ocr_pkg::OCR_CUR_POS_LSB +: 2];
      ch2_load_or_neg_pin_q <= EE_CTL_I[ocr_pkg::OCR_LOAD_NEG_LSB +: 2];
    end
  end

  // Bit 0 holds no storage and always reads zero
  assign ch2_output_control = {reserved_bit_q, ch2_format_q, ch2_current_or_pos_pin_q,
                               ch2_load_or_neg_pin_q, 1'b0};

  // ****************************************
  // Read port and EEPROM image
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= ocr_pkg::OCR_UNMAPPED_READ;
    end else if (RD_I) begin
      unique case (ADDR_I)
        ocr_pkg::OCR_CH01_OUTPUT_DIVIDER_OFS: RDATA_O <= ch01_output_divider_q;
        ocr_pkg::OCR_CH2_OUTPUT_CONTROL_OFS: RDATA_O <= ch2_output_control;
        default: RDATA_O <= ocr_pkg::OCR_UNMAPPED_READ;
      endcase
    end else begin
      RDATA_O <= ocr_pkg::OCR_UNMAPPED_READ;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      EE_DIV_O <= ocr_pkg::OCR_CH01_DIV_RST;
    end else begin
      EE_DIV_O <= ch01_output_divider_q;
    end
  end

  // Image of the control register; bit 0 never reaches the EEPROM
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      EE_CTL_O <= {ocr_pkg::OCR_RESERVED_BIT_RST, ocr_pkg::OCR_CH2_FORMAT_RST, ocr_pkg::OCR_CH2_CUR_POS_RST,
                   ocr_pkg::OCR_CH2_LOAD_NEG_RST, 1'b0};
    end else begin
      EE_CTL_O <= ch2_output_control;
    end
  end

  // ****************************************
  // Shared channel 0/1 divider
  // ****************************************
  assign div_bus.div_code = ch01_output_divider_q;

  ocr_divider u_divider (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .div(div_bus.divider)
  );

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CH01_TICK_O <= 1'b0;
    end else begin
      CH01_TICK_O <= div_bus.tick;
    end
  end

  // ****************************************
  // Channel 2 differential decode
  // ****************************************
  always_comb begin
    tail_ma_d = 5'h00;
    load_ohm_d = 8'h00;
    if (ch2_format_q == ocr_pkg::OCR_FMT_AC_DIFF || ch2_format_q == ocr_pkg::OCR_FMT_HCSL) begin
      unique case (ch2_current_or_pos_pin_q)
        2'h0: tail_ma_d = ocr_pkg::OCR_TAIL_4MA;
        2'h1: tail_ma_d = ocr_pkg::OCR_TAIL_6MA;
        2'h2: tail_ma_d = ocr_pkg::OCR_TAIL_8MA;
        2'h3: tail_ma_d = (ch2_format_q == ocr_pkg::OCR_FMT_HCSL) ?
                          ocr_pkg::OCR_TAIL_16MA : ocr_pkg::OCR_TAIL_8MA;
      endcase
    end
    if (ch2_format_q == ocr_pkg::OCR_FMT_HCSL) begin
      unique case (ch2_load_or_neg_pin_q)
        2'h0: load_ohm_d = 8'h00;
        2'h1: load_ohm_d = ocr_pkg::OCR_LOAD_50OHM;
        2'h2: load_ohm_d = ocr_pkg::OCR_LOAD_100OHM;
        2'h3: load_ohm_d = ocr_pkg::OCR_LOAD_200OHM;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CH2_FORMAT_O <= ocr_pkg::OCR_CH2_FORMAT_RST;
      CH2_TAIL_MA_O <= ocr_pkg::OCR_TAIL_8MA;
      CH2_LOAD_OHM_O <= 8'h00;
    end else begin
      CH2_FORMAT_O <= ch2_format_q;
      CH2_TAIL_MA_O <= tail_ma_d;
      CH2_LOAD_OHM_O <= load_ohm_d;
    end
  end

  // ****************************************
  // Channel 2 LVCMOS pin decode
  // ****************************************
  // Index 0 is the positive pin, index 1 the negative pin
  assign pin_code[0] = ch2_current_or_pos_pin_q;
  assign pin_code[1] = ch2_load_or_neg_pin_q;

  // Outside LVCMOS both pins stay powered down and released
  for (genvar p = 0; p < 2; p++) begin : g_pin
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        pin_powered_q[p] <= 1'b0;
        pin_oe_n_q[p] <= 1'b1;
        pin_invert_q[p] <= 1'b0;
      end else if (ch2_format_q == ocr_pkg::OCR_FMT_LVCMOS) begin
        pin_powered_q[p] <= pin_code[p][1];
        pin_oe_n_q[p] <= (pin_code[p] == ocr_pkg::OCR_PIN_OFF_TRISTATE);
        pin_invert_q[p] <= (pin_code[p] == ocr_pkg::OCR_PIN_ON_INVERTED);
      end else begin
        pin_powered_q[p] <= 1'b0;
        pin_oe_n_q[p] <= 1'b1;
        pin_invert_q[p] <= 1'b0;
      end
    end
  end

  assign CH2_POS_POWERED_O = pin_powered_q[0];
  assign CH2_POS_OE_N_O = pin_oe_n_q[0];
  assign CH2_POS_INVERT_O = pin_invert_q[0];
  assign CH2_NEG_POWERED_O = pin_powered_q[1];
  assign CH2_NEG_OE_N_O = pin_oe_n_q[1];
  assign CH2_NEG_INVERT_O = pin_invert_q[1];

endmodule

// File: ocr_regs_monitor.sv
// Port checker for the output channel configuration registers
module ocr_regs_monitor (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Register port and images
  input wire logic [7:0] ADDR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic [7:0] EE_DIV_O,
  input wire logic [7:0] EE_CTL_O,
  // Driver outputs
  input wire logic CH01_TICK_O,
  input wire logic [1:0] CH2_FORMAT_O,
  input wire logic [4:0] CH2_TAIL_MA_O,
  input wire logic [7:0] CH2_LOAD_OHM_O,
  input wire logic CH2_POS_POWERED_O,
  input wire logic CH2_POS_OE_N_O,
  input wire logic CH2_POS_INVERT_O,
  input wire logic CH2_NEG_POWERED_O,
  input wire logic CH2_NEG_OE_N_O,
  input wire logic CH2_NEG_INVERT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_q;
  logic [1:0] f;
  logic [1:0] a;
  logic [1:0] b;
  assign f = EE_CTL_O[6:5];
  assign a = EE_CTL_O[4:3];
  assign b = EE_CTL_O[2:1];
  // Cycles since reset release, saturating
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_div_held(v);
    (EE_DIV_O == v) [*4];
  endsequence
  property p_div_one;
    s_div_held(8'h00) |-> CH01_TICK_O;
  endproperty
  property p_div_two;
    up_q == 3'h7 ##0 s_div_held(8'h01) |-> CH01_TICK_O != $past(CH01_TICK_O);
  endproperty
  property p_rst_img;
    disable iff (1'b0) $rose(RST_N_I) |-> EE_DIV_O == 8'h01 && EE_CTL_O == 8'hB0;
  endproperty
  property p_rd_div;
    $past(RD_I && ADDR_I == 8'h21) |-> RDATA_O == EE_DIV_O;
  endproperty
  property p_rd_ctl;
    $past(RD_I && ADDR_I == 8'h22) |-> RDATA_O == EE_CTL_O && !RDATA_O[0];
  endproperty
  property p_fmt;
    CH2_FORMAT_O == f;
  endproperty
  property p_tail;
    f == 2'h1 || f == 2'h2 |-> CH2_TAIL_MA_O == (a == 2'h3 ? (f == 2'h2 ? 5'h10 : 5'h08) : 5'h04 + 5'(a) * 5'h02);
  endproperty
  property p_load;
    f == 2'h2 |-> CH2_LOAD_OHM_O == (b == 2'h0 ? 8'h00 : 8'h19 << b);
  endproperty
  property p_pos;
    f == 2'h3 |-> {CH2_POS_POWERED_O, CH2_POS_OE_N_O, CH2_POS_INVERT_O} == {a[1], a == 2'h0, a == 2'h2};
  endproperty
  property p_neg;
    f == 2'h3 |-> {CH2_NEG_POWERED_O, CH2_NEG_OE_N_O, CH2_NEG_INVERT_O} == {b[1], b == 2'h0, b == 2'h2};
  endproperty
  a_div_one: assert property (p_div_one) else $error("tick not constant at ratio one");
  a_div_two: assert property (p_div_two) else $error("tick not alternating at ratio two");
  a_rst_img: assert property (p_rst_img) else $error("reset images wrong");
  a_rd_div: assert property (p_rd_div) else $error("divider readback wrong");
  a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
  a_fmt: assert property (p_fmt) else $error("format output wrong");
  a_tail: assert property (p_tail) else $error("tail current wrong");
  a_load: assert property (p_load) else $error("load value wrong");
  a_pos: assert property (p_pos) else $error("positive pin state wrong");
  a_neg: assert property (p_neg) else $error("negative pin state wrong");
endmodule

bind ocr_output_channel_config_regs ocr_regs_monitor u_mon (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
  .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .EE_DIV_O(EE_DIV_O), .EE_CTL_O(EE_CTL_O),
  .CH01_TICK_O(CH01_TICK_O), .CH2_FORMAT_O(CH2_FORMAT_O), .CH2_TAIL_MA_O(CH2_TAIL_MA_O),
  .CH2_LOAD_OHM_O(CH2_LOAD_OHM_O), .CH2_POS_POWERED_O(CH2_POS_POWERED_O), .CH2_POS_OE_N_O(CH2_POS_OE_N_O),
  .CH2_POS_INVERT_O(CH2_POS_INVERT_O), .CH2_NEG_POWERED_O(CH2_NEG_POWERED_O),
  .CH2_NEG_OE_N_O(CH2_NEG_OE_N_O), .CH2_NEG_INVERT_O(CH2_NEG_INVERT_O));

// File: ocr_output_channel_config_regs_tb_top.sv
// Self-checking bench of the output channel configuration registers
module ocr_output_channel_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ld = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] edv = 8'h00;
  logic [7:0] ect = 8'h00;
  logic [7:0] rdata, ediv, ectl, load;
  logic [4:0] tail;
  logic [1:0] fmt;
  logic tick, pp, po, pi, np, no, ni;
  logic [15:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;

  ocr_output_channel_config_regs DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .EE_LOAD_I(ld), .EE_DIV_I(edv), .EE_CTL_I(ect),
    .EE_DIV_O(ediv), .EE_CTL_O(ectl), .CH01_TICK_O(tick), .CH2_FORMAT_O(fmt), .CH2_TAIL_MA_O(tail),
    .CH2_LOAD_OHM_O(load), .CH2_POS_POWERED_O(pp), .CH2_POS_OE_N_O(po), .CH2_POS_INVERT_O(pi),
    .CH2_NEG_POWERED_O(np), .CH2_NEG_OE_N_O(no), .CH2_NEG_INVERT_O(ni));

  always #2.5 clk = ~clk;

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ****************************************
  // Register port tasks, entered just after a rising edge; an idle cycle follows each strobe
  // ****************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(16'(e));
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand in the cycle after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q) begin
      chk(16'(rdata), exp_q.pop_front());
    end
  end

  task automatic chk_dec(input logic [7:0] v);
    logic [1:0] f, a, b;
    f = v[6:5];
    a = v[4:3];
    b = v[2:1];
    @(negedge clk);
    chk(16'(fmt), 16'(f));
    chk(16'(tail), (f == 2'h1 || f == 2'h2) ? (a == 2'h3 ? (f == 2'h2 ? 16'h10 : 16'h08) : 16'h04 + 16'(a) * 16'h02) : 16'h00);
    chk(16'(load), (f == 2'h2 && b != 2'h0) ? 16'h19 << b : 16'h00);
    chk(16'({pp, po, pi}), f == 2'h3 ? 16'({a[1], a == 2'h0, a == 2'h2}) : 16'h02);
    chk(16'({np, no, ni}), f == 2'h3 ? 16'({b[1], b == 2'h0, b == 2'h2}) : 16'h02);
  endtask

  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (tick !== 1'b1 && c < 300);
    if (c == 300) begin
      err_total++;
      end_of_test();
    end
  endtask

  initial begin
    logic [7:0] v;
    logic [7:0] divs[5];
    int c;
    void'($urandom(52));
    divs = '{8'h00, 8'h01, 8'h04, 8'hFF, 8'($urandom)};
    for (int r = 0; r < 2; r++) begin
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_reg(8'h21, 8'h01);
      rd_reg(8'h22, 8'hB0);
      rd_reg(8'h23, 8'h00);
      chk_dec(8'hB0);
      @(posedge clk);
      $display("Test reset %0d done", r);
      for (int i = 0; i < 64; i++) begin
        v = {1'b0, 6'(i), 1'($urandom)};
        wr_reg(8'h22, v);
        rd_reg(8'h22, {v[7:1], 1'b0});
        wr_reg(8'h20, 8'($urandom));
        rd_reg(8'h22, {v[7:1], 1'b0});
        chk_dec(v);
        @(posedge clk);
      end
      $display("Test control sweep done");
      foreach (divs[k]) begin
        wr_reg(8'h21, divs[k]);
        rd_reg(8'h21, divs[k]);
        wait_tick(c);
        wait_tick(c);
        wait_tick(c);
        chk(16'(c), 16'(divs[k]) + 16'h01);
        @(posedge clk);
      end
      $display("Test divider done");
      edv <= 8'($urandom);
      ect <= 8'($urandom);
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      rd_reg(8'h21, edv);
      rd_reg(8'h22, {ect[7:1], 1'b0});
      @(negedge clk);
      chk(16'(ediv), 16'(edv));
      chk(16'(ectl), 16'({ect[7:1], 1'b0}));
      @(posedge clk);
      $display("Test image load done");
    end
    end_of_test();
  end
endmodule
